// ==== logic/light_readout.sv ====
// Ambient light parameter register, result registers and measurement sequencer.
// Assumes a register port decoded from the serial bus and a converter on mclk.
module light_readout #(
    parameter int SEC_CYCLES = light_pkg::SECOND_CYCLES,    // cycles in one second
    parameter int GAP_CYCLES = light_pkg::SETTLE_CYCLES     // settle time between conversions
) (
    input wire logic mclk,                                  // system clock
    input wire logic reset,                                 // synchronous, active high
    input wire light_pkg::reg_req_t reg_req,                // register access
    output logic [7:0] reg_rdata,                           // read data, one cycle after rd
    input wire logic selftimed_en,                          // self-timed state machine enabled
    input wire logic light_periodic_en,                     // periodic ambient measurement enabled
    input wire logic light_ondemand_trigger,                // one-cycle on-demand request
    output logic meas_busy,                                 // measurement run in progress
    output logic result_ready,                              // one-cycle pulse, new result stored
    output logic adc_start,                                 // one-cycle conversion start
    output logic adc_offset,                                // conversion measures the dark offset
    input wire logic adc_done,                              // conversion complete
    input wire logic [light_pkg::RES_W-1:0] adc_data        // conversion value
);
    import light_pkg::*;

    if (SEC_CYCLES < 8 || GAP_CYCLES < 1) begin : g_bad_params
        $error("light_readout: SEC_CYCLES must be at least 8, GAP_CYCLES at least 1");
    end

    light_param_t shadow_q;
    light_param_t active_q;
    logic [RES_W-1:0] result_q;
    logic [RES_W-1:0] result_d;
    logic [RES_W-1:0] offset_q;
    logic [RES_W-1:0] mean;
    logic [7:0] conv_cnt_q;
    logic [7:0] conv_total;
    logic [31:0] rate_acc_q;
    logic [31:0] rate_next;
    logic [31:0] gap_cnt_q;
    logic rate_tick;
    logic ondemand_run_q;
    logic last_conv;
    logic skip_gap;
    logic start_run;
    logic sample_valid;
    seq_state_t state_q;
    seq_state_t state_d;

    // ==========================================================
    // Parameter register
    always_ff @(posedge mclk) begin
        if (reset) begin
            shadow_q <= PARAM_RESET;
        end else if (reg_req.wr && reg_req.addr == ADDR_PARAM) begin
            shadow_q <= light_param_t'(reg_req.wdata);
        end
    end

    // Values in use are frozen while self-timed mode runs
    always_ff @(posedge mclk) begin
        if (reset) begin
            active_q <= PARAM_RESET;
        end else if (!selftimed_en) begin
            active_q <= shadow_q;
        end
    end

    // ==========================================================
    // Register read port; result bytes have no write path
    always_ff @(posedge mclk) begin
        if (reset) begin
            reg_rdata <= RDATA_UNMAPPED;
        end else if (reg_req.rd) begin
            case (reg_req.addr)
                ADDR_PARAM: reg_rdata <= shadow_q;
                ADDR_RES_HI: reg_rdata <= result_q[15:8];
                ADDR_RES_LO: reg_rdata <= result_q[7:0];
                default: reg_rdata <= RDATA_UNMAPPED;
            endcase
        end
    end

    // ==========================================================
    // Self-timed rate: adds runs-per-second (rate code + 1) each cycle, wraps once per run
    always_comb begin
        rate_next = rate_acc_q + 32'(active_q.rate) + 32'h1;
        rate_tick = rate_next >= 32'(SEC_CYCLES);
    end

    always_ff @(posedge mclk) begin
        if (reset || !(selftimed_en && light_periodic_en)) begin
            rate_acc_q <= '0;
        end else if (rate_tick) begin
            rate_acc_q <= rate_next - 32'(SEC_CYCLES);
        end else begin
            rate_acc_q <= rate_next;
        end
    end

    // On-demand requests are ignored while self-timed mode is enabled
    always_comb begin
        start_run = (selftimed_en && light_periodic_en && rate_tick) || (!selftimed_en && light_ondemand_trigger);
    end

    // ==========================================================
    // Sequencer
    always_comb begin
        conv_total = 8'h1 << active_q.avg;
        last_conv = conv_cnt_q == conv_total - 8'h1;
        skip_gap = active_q.cont && ondemand_run_q;
        sample_valid = state_q == ST_CONV_WAIT && adc_done;
    end

    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (start_run) begin
                    state_d = active_q.offs_en ? ST_OFFS_START : ST_CONV_START;
                end
            end
            ST_OFFS_START: state_d = ST_OFFS_WAIT;
            ST_OFFS_WAIT: begin
                if (adc_done) begin
                    state_d = skip_gap ? ST_CONV_START : ST_GAP;
                end
            end
            ST_CONV_START: state_d = ST_CONV_WAIT;
            ST_CONV_WAIT: begin
                if (adc_done) begin
                    if (last_conv) begin
                        state_d = ST_STORE;
                    end else begin
                        state_d = skip_gap ? ST_CONV_START : ST_GAP;
                    end
                end
            end
            ST_GAP: begin
                if (gap_cnt_q == 32'(GAP_CYCLES - 1)) begin
                    state_d = ST_CONV_START;
                end
            end
            ST_STORE: state_d = ST_IDLE;
            default: state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            ondemand_run_q <= 1'b0;
        end else if (state_q == ST_IDLE && start_run) begin
            ondemand_run_q <= !selftimed_en;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset || state_q != ST_GAP) begin
            gap_cnt_q <= '0;
        end else begin
            gap_cnt_q <= gap_cnt_q + 32'h1;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset || state_q == ST_IDLE) begin
            conv_cnt_q <= '0;
        end else if (sample_valid) begin
            conv_cnt_q <= conv_cnt_q + 8'h1;
        end
    end

    // No offset measured means nothing to subtract
    always_ff @(posedge mclk) begin
        if (reset || (state_q == ST_IDLE && start_run)) begin
            offset_q <= '0;
        end else if (state_q == ST_OFFS_WAIT && adc_done) begin
            offset_q <= adc_data;
        end
    end

    light_averager u_avg (
        .mclk(mclk),
        .reset(reset),
        .clear(state_q == ST_IDLE),
        .sample_valid(sample_valid),
        .sample(adc_data),
        .avg_code(active_q.avg),
        .mean(mean)
    );

    // Offset above the mean clamps to zero instead of wrapping
    always_comb begin
        result_d = (mean > offset_q) ? mean - offset_q : '0;
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            result_q <= '0;
        end else if (state_q == ST_STORE) begin
            result_q <= result_d;
        end
    end

    // ==========================================================
    // Output flops
    always_ff @(posedge mclk) begin
        if (reset) begin
            adc_start <= 1'b0;
            adc_offset <= 1'b0;
            meas_busy <= 1'b0;
            result_ready <= 1'b0;
        end else begin
            adc_start <= state_d == ST_OFFS_START || state_d == ST_CONV_START;
            adc_offset <= state_d == ST_OFFS_START || state_d == ST_OFFS_WAIT;
            meas_busy <= state_d != ST_IDLE;
            result_ready <= state_q == ST_STORE;
        end
    end

    // ==========================================================
    // Assertions
    logic [RES_W-1:0] last_sample_q;
    always_ff @(posedge mclk) begin
        if (sample_valid) begin
            last_sample_q <= adc_data;
        end
    end

    a_param_write: assert property (@(posedge mclk) disable iff (reset)
        reg_req.wr && reg_req.addr == ADDR_PARAM |=> shadow_q == $past(reg_req.wdata))
        else $error("parameter write not stored");

    a_param_reset: assert property (@(posedge mclk)
        $past(reset) |-> shadow_q == PARAM_RESET && active_q == PARAM_RESET)
        else $error("parameter reset value wrong");

    a_active_frozen: assert property (@(posedge mclk) disable iff (reset)
        $past(selftimed_en) && selftimed_en |=> $stable(active_q))
        else $error("parameters changed during self-timed mode");

    a_result_ro: assert property (@(posedge mclk) disable iff (reset)
        reg_req.wr && state_q != ST_STORE |=> $stable(result_q))
        else $error("result changed without a measurement");

    a_read_high: assert property (@(posedge mclk) disable iff (reset)
        reg_req.rd && reg_req.addr == ADDR_RES_HI && state_q != ST_STORE |=> reg_rdata == result_q[15:8])
        else $error("high result byte read wrong");

    a_read_low: assert property (@(posedge mclk) disable iff (reset)
        reg_req.rd && reg_req.addr == ADDR_RES_LO && state_q != ST_STORE |=> reg_rdata == result_q[7:0])
        else $error("low result byte read wrong");

    a_offset_first: assert property (@(posedge mclk) disable iff (reset)
        state_q == ST_IDLE && start_run && active_q.offs_en |=> state_q == ST_OFFS_START ##1 adc_offset)
        else $error("offset not measured first");

    a_conv_count: assert property (@(posedge mclk) disable iff (reset)
        state_q == ST_STORE |-> conv_cnt_q == conv_total)
        else $error("wrong number of conversions in run");

    a_gap_kept: assert property (@(posedge mclk) disable iff (reset)
        sample_valid && !last_conv && !ondemand_run_q |=> state_q == ST_GAP)
        else $error("self-timed run skipped settle gap");

    a_cont_skip: assert property (@(posedge mclk) disable iff (reset)
        sample_valid && !last_conv && skip_gap |=> state_q == ST_CONV_START)
        else $error("continuous run kept settle gap");

    a_single_mean: assert property (@(posedge mclk) disable iff (reset)
        state_q == ST_STORE && active_q.avg == 3'h0 && !active_q.offs_en |=> result_q == last_sample_q)
        else $error("single conversion result wrong");

    a_result_stored: assert property (@(posedge mclk) disable iff (reset)
        state_q == ST_STORE |=> result_ready && result_q == $past(result_d))
        else $error("result not stored at end of run");

    c_ondemand_run: cover property (@(posedge mclk) disable iff (reset)
        ondemand_run_q && result_ready);
    c_selftimed_run: cover property (@(posedge mclk) disable iff (reset)
        !ondemand_run_q && result_ready);
    c_cont_run: cover property (@(posedge mclk) disable iff (reset)
        active_q.cont && ondemand_run_q && state_q == ST_STORE);
    c_offset_clamp: cover property (@(posedge mclk) disable iff (reset)
        state_q == ST_STORE && offset_q > mean);

endmodule // light_readout

// ==== logic/light_pkg.sv ====
// Constants, register map and carrier types of the ambient light readout.
// Assumes one 100 MHz clock shared by register port, sequencer and converter.
package light_pkg;

    // ==========================================================
    // Register map
    localparam logic [7:0] ADDR_PARAM = 8'h84;
    localparam logic [7:0] ADDR_RES_HI = 8'h85;
    localparam logic [7:0] ADDR_RES_LO = 8'h86;
    localparam logic [7:0] RDATA_UNMAPPED = 8'h00;

    // ==========================================================
    // Parameter register fields
    localparam int CONT_BIT = 7;
    localparam int RATE_LSB = 4;
    localparam int RATE_W = 3;
    localparam int OFFS_BIT = 3;
    localparam int AVG_LSB = 0;
    localparam int AVG_W = 3;
    localparam int AVG_MAX_CODE = 7;

    typedef struct packed {
        logic cont;                  // bit 7
        logic [RATE_W-1:0] rate;     // bits 6:4
        logic offs_en;               // bit 3
        logic [AVG_W-1:0] avg;       // bits 2:0
    } light_param_t;

    localparam light_param_t PARAM_RESET = '{cont: 1'b0, rate: 3'h0, offs_en: 1'b1, avg: 3'h5};

    // ==========================================================
    // Result and converter widths
    localparam int RES_W = 16;
    localparam int SUM_W = RES_W + AVG_MAX_CODE;

    // ==========================================================
    // Register port request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    // ==========================================================
    // Timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int SETTLE_NS = 1000;
    localparam int SETTLE_CYCLES = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SECOND_NS = 1000000000;
    localparam int SECOND_CYCLES = SECOND_NS / CLK_PERIOD_NS;

    // ==========================================================
    // Sequencer states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_OFFS_START = 3'b001,
        ST_OFFS_WAIT = 3'b010,
        ST_CONV_START = 3'b011,
        ST_CONV_WAIT = 3'b100,
        ST_GAP = 3'b101,
        ST_STORE = 3'b110
    } seq_state_t;

endpackage

// ==== logic/light_averager.sv ====
// Accumulates the single conversions of one run and forms their mean.
// Assumes the sequencer clears it before each run and feeds at most 2^7 samples.
module light_averager (
    input wire logic mclk,                                  // system clock
    input wire logic reset,                                 // synchronous, active high
    input wire logic clear,                                 // start of run
    input wire logic sample_valid,                          // one sample this cycle
    input wire logic [light_pkg::RES_W-1:0] sample,         // converter sample
    input wire logic [light_pkg::AVG_W-1:0] avg_code,       // log2 of samples per run
    output logic [light_pkg::RES_W-1:0] mean                // sum divided by 2^avg_code
);
    import light_pkg::*;

    logic [SUM_W-1:0] sum_q;
    logic [SUM_W-1:0] shifted;

    // ==========================================================
    // Accumulator
    always_ff @(posedge mclk) begin
        if (reset || clear) begin
            sum_q <= '0;
        end else if (sample_valid) begin
            sum_q <= sum_q + {{(SUM_W-RES_W){1'b0}}, sample};
        end
    end

    // Power-of-two count makes the division a plain shift
    always_comb begin
        shifted = sum_q >> avg_code;
        mean = shifted[RES_W-1:0];
    end

endmodule // light_averager

// ==== tb/light_adc_model.sv ====
// Behavioural converter on the far side of the readout's conversion port.
// Assumes one adc_start per conversion; answers DLY cycles later, never at once.
module light_adc_model #(
    parameter int DLY = 3
) (
    input wire logic mclk,              // system clock
    input wire logic clr,               // zero the counters
    input wire logic adc_start,         // conversion request
    input wire logic adc_offset,        // dark offset conversion
    input wire logic [15:0] offs_val,   // value of offset conversions
    input wire logic [15:0] base_val,   // first light sample, later ones count up
    output logic adc_done,              // conversion complete
    output logic [15:0] adc_data,       // sample, valid with adc_done only
    output int starts,                  // conversions requested since clr
    output int last_gap                 // idle cycles before the latest request
);
    timeunit 1ns;
    timeprecision 100ps;
    int cnt = 0;
    int k = 0;
    int idle = 0;
    logic busy = 1'b0;
    logic offs = 1'b0;
    logic [15:0] last = 16'h0000;
    initial begin
        adc_done = 1'b0;
        adc_data = 16'hffff;
        starts = 0;
        last_gap = 0;
    end
    always @(posedge mclk) begin
        adc_done <= 1'b0;
        // Outside the done cycle the data lines carry garbage
        adc_data <= ~last;
        idle <= idle + 1;
        if (clr) begin
            starts <= 0;
            k <= 0;
        end else if (adc_start) begin
            starts <= starts + 1;
        end
        if (adc_start) begin
            busy <= 1'b1;
            cnt <= DLY;
            offs <= adc_offset;
            last_gap <= idle;
        end else if (busy && cnt == 1) begin
            busy <= 1'b0;
            adc_done <= 1'b1;
            idle <= 0;
            last <= offs ? offs_val : base_val + 16'(k);
            adc_data <= offs ? offs_val : base_val + 16'(k);
            if (!offs) begin
                k <= k + 1;
            end
        end else if (busy) begin
            cnt <= cnt - 1;
        end
    end
endmodule // light_adc_model

// ==== tb/tb_light_readout.sv ====
// Self-checking bench for the ambient light readout.
// Assumes light_pkg and the converter model; host accesses made from tasks.
module tb_light_readout;
    timeunit 1ns;
    timeprecision 100ps;
    import light_pkg::*;
    localparam int GAP = 4;
    typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] e;} rrow_t;
    typedef struct packed {logic [7:0] p; logic [15:0] b; logic [15:0] o;} mrow_t;
    localparam rrow_t RROWS [6] = '{'{8'h84, 8'hff, 8'hff}, '{8'h84, 8'h00, 8'h00}, '{8'h84, 8'h0d, 8'h0d},
        '{8'h85, 8'haa, 8'h00}, '{8'h86, 8'h55, 8'h00}, '{8'h90, 8'h12, 8'h00}};
    localparam mrow_t MROWS [4] = '{'{8'h00, 16'h1234, 16'h0000}, '{8'h0a, 16'h0100, 16'h0010},
        '{8'h0b, 16'h0005, 16'h0020}, '{8'h07, 16'h8000, 16'h0000}};
    logic mclk, reset, selftimed_en, light_periodic_en, trig, clr;
    reg_req_t req;
    logic [7:0] rdata, b_hi, b_lo;
    logic meas_busy, result_ready, adc_start, adc_offset, adc_done;
    logic [RES_W-1:0] adc_data, offs_val, base_val;
    int starts, last_gap, error_cnt, checks, g_nc;

    light_readout #(.SEC_CYCLES(100), .GAP_CYCLES(GAP)) u_dut (.mclk(mclk), .reset(reset), .reg_req(req),
        .reg_rdata(rdata), .selftimed_en(selftimed_en), .light_periodic_en(light_periodic_en),
        .light_ondemand_trigger(trig), .meas_busy(meas_busy), .result_ready(result_ready),
        .adc_start(adc_start), .adc_offset(adc_offset), .adc_done(adc_done), .adc_data(adc_data));
    light_adc_model #(.DLY(3)) u_adc (.mclk(mclk), .clr(clr), .adc_start(adc_start), .adc_offset(adc_offset),
        .offs_val(offs_val), .base_val(base_val), .adc_done(adc_done), .adc_data(adc_data),
        .starts(starts), .last_gap(last_gap));

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // ==========================================================
    // Helpers
    task automatic end_sim();
        $display("Comparisons %0d, mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic check16(input logic [15:0] got, input logic [15:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
        cyc(1);
        req = '{wr: w, rd: !w, addr: a, wdata: d};
        cyc(1);
        req = '0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        access(1'b0, a, 8'h00);
        d = rdata;
    endtask
    task automatic pulse_clr();
        clr = 1'b1;
        cyc(1);
        clr = 1'b0;
    endtask
    task automatic wait_ready(input int bound);
        int n;
        n = 0;
        while (result_ready !== 1'b1) begin
            cyc(1);
            n++;
            if (n > bound) begin
                error_cnt++;
                $display("Error at %0t: no result within bound", $time);
                end_sim();
            end
        end
    endtask
    // Mean of the model's counting samples, less the dark offset, never below zero
    function automatic logic [15:0] exp_mean(input logic [7:0] p, input logic [15:0] b, input logic [15:0] o);
        logic [23:0] sum;
        logic [15:0] m;
        sum = '0;
        for (int i = 0; i < (1 << p[2:0]); i++) sum += 24'(b) + 24'(i);
        m = 16'(sum >> p[2:0]);
        if (p[3] && o > m) return 16'h0000;
        return p[3] ? m - o : m;
    endfunction
    task automatic measure(input logic [7:0] p, input logic [15:0] b, input logic [15:0] o);
        access(1'b1, 8'h84, p);
        base_val = b;
        offs_val = o;
        pulse_clr();
        trig = 1'b1;
        cyc(1);
        trig = 1'b0;
        check16(16'(meas_busy), 16'h0001, "busy in run");
        wait_ready(5000);
        rd(8'h85, b_hi);
        rd(8'h86, b_lo);
        check16({b_hi, b_lo}, exp_mean(p, b, o), "result");
        check16(16'(starts), 16'((1 << p[2:0]) + p[3]), "conversions");
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        reset = 1'b1;
        req = '0;
        selftimed_en = 1'b0;
        light_periodic_en = 1'b0;
        trig = 1'b0;
        clr = 1'b0;
        base_val = 16'h0000;
        offs_val = 16'h0000;
        error_cnt = 0;
        checks = 0;
        cyc(6);
        reset = 1'b0;
        rd(8'h84, b_lo);
        check16(16'(b_lo), 16'h000d, "param reset");
        foreach (RROWS[i]) begin
            access(1'b1, RROWS[i].a, RROWS[i].d);
            rd(RROWS[i].a, b_lo);
            check16(16'(b_lo), 16'(RROWS[i].e), "register");
        end
        foreach (MROWS[i]) measure(MROWS[i].p, MROWS[i].b, MROWS[i].o);
        // Continuous mode drops the settle gap between conversions of on-demand runs
        measure(8'h01, 16'h0200, 16'h0000);
        g_nc = last_gap;
        measure(8'h81, 16'h0200, 16'h0000);
        check16(16'(g_nc - last_gap >= GAP), 16'h0001, "settle gap");
        // Self-timed: a write while running waits until the mode is cycled
        access(1'b1, 8'h84, 8'h00);
        cyc(2);
        selftimed_en = 1'b1;
        light_periodic_en = 1'b1;
        access(1'b1, 8'h84, 8'h02);
        base_val = 16'h0040;
        pulse_clr();
        wait_ready(400);
        check16(16'(starts), 16'h0001, "frozen avg");
        selftimed_en = 1'b0;
        cyc(2);
        selftimed_en = 1'b1;
        pulse_clr();
        wait_ready(400);
        check16(16'(starts), 16'h0004, "applied avg");
        selftimed_en = 1'b0;
        light_periodic_en = 1'b0;
        cyc(60);
        // Rate code 3 is four runs per SEC_CYCLES; 200 cycles give 8, the last may still be in flight
        access(1'b1, 8'h84, 8'h30);
        cyc(2);
        pulse_clr();
        selftimed_en = 1'b1;
        light_periodic_en = 1'b1;
        cyc(200);
        selftimed_en = 1'b0;
        light_periodic_en = 1'b0;
        check16(16'(starts >= 7 && starts <= 8), 16'h0001, "rate code 3");
        cyc(20);
        // Reset in the middle of a run
        access(1'b1, 8'h84, 8'hff);
        trig = 1'b1;
        cyc(1);
        trig = 1'b0;
        cyc(3);
        reset = 1'b1;
        cyc(2);
        reset = 1'b0;
        check16(16'(meas_busy), 16'h0000, "busy after reset");
        rd(8'h84, b_lo);
        check16(16'(b_lo), 16'h000d, "param after reset");
        rd(8'h85, b_hi);
        rd(8'h86, b_lo);
        check16({b_hi, b_lo}, 16'h0000, "result after reset");
        end_sim();
    end
endmodule // tb_light_readout
